//--- logic/arg_pkg.sv
// Constants, register map and types for the analog ramp generator
package arg_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int UPDATE_MS = 100;
  localparam int UPDATE_CYCLES = CLK_HZ / 1000 * UPDATE_MS;
  localparam int RATE_MIN = 1;
  localparam int RATE_MAX = 10_000;
  localparam int UPDATES_PER_SEC = 1000 / UPDATE_MS;
  localparam int GAIN_SCALE = 100;
  localparam int DIV_W = 24;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TGT_LOW = 8'h04;
  localparam logic [7:0] REG_TGT_HIGH = 8'h08;
  localparam logic [7:0] REG_LIMIT = 8'h0C;
  localparam logic [7:0] REG_START_STOP_OFFSET = 8'h10;
  localparam logic [7:0] REG_RATE = 8'h14;
  localparam logic [7:0] REG_GAIN = 8'h18;
  localparam logic [7:0] REG_OFFSET = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_LEVEL = 8'h24;
  localparam logic [7:0] REG_OUTPUT = 8'h28;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int STAT_LOCK_BIT = 3;

  localparam logic [15:0] RST_TGT = 16'h0000;
  localparam logic [15:0] RST_LIMIT = 16'h4E20;
  localparam logic [15:0] RST_START_STOP_OFFSET = 16'h0000;
  localparam logic [15:0] RST_RATE = 16'h0064;
  localparam logic [15:0] RST_GAIN = 16'h0064;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] OUT_MAX = 16'h7FFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic signed [17:0] arg_level_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START_HOLD, ST_RAMP, ST_DECEL, ST_STOP_HOLD, ST_LOCKED
  } arg_state_e;
endpackage : arg_pkg

//--- logic/arg_div_if.sv
// Carrier between the ramp top and its scaling divider
`timescale 1ns/1ns
`default_nettype none
interface arg_div_if #(parameter int W = 24);
  logic start;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic done;
  logic [W-1:0] quotient;
  modport master(output start, output dividend, output divisor,
                 input done, input quotient);
  modport server(input start, input dividend, input divisor,
                 output done, output quotient);
endinterface : arg_div_if
`default_nettype wire

//--- logic/arg_tick.sv
// Update tick generator, restartable so holds last a full period
`timescale 1ns/1ns
`default_nettype none
module arg_tick #(
  parameter int CYCLES = arg_pkg::UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick
);
  localparam int W = $clog2(CYCLES);
  logic [W-1:0] count;
  wire last = (count == W'(CYCLES - 1));

  generate
    if (CYCLES < 2) begin : g_bad
      $error("arg_tick needs at least two cycles per period");
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      tick <= last && !clear;
      count <= (clear || last) ? '0 : count + 1'b1;
    end
  end
endmodule : arg_tick
`default_nettype wire

//--- logic/arg_div.sv
// Restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ns
`default_nettype none
module arg_div #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  arg_div_if.server bus
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0] quo;
  logic [W-1:0] den;
  logic [W:0] rem;
  logic [CW-1:0] left;
  wire [W:0] shifted = {rem[W-1:0], quo[W-1]};
  wire [W:0] trial = shifted - {1'b0, den};
  wire fits = !trial[W];

  assign bus.quotient = quo;

  // Zero divisor always fits, so the quotient saturates to all ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quo <= '0;
      den <= '0;
      rem <= '0;
      left <= '0;
      bus.done <= 1'b0;
    end else begin
      bus.done <= (left == CW'(1));
      if (bus.start && left == '0) begin
        quo <= bus.dividend;
        den <= bus.divisor;
        rem <= '0;
        left <= CW'(W);
      end else if (left != '0) begin
        rem <= fits ? trial : shifted;
        quo <= {quo[W-2:0], fits};
        left <= left - 1'b1;
      end
    end
  end
endmodule : arg_div
`default_nettype wire

//--- logic/arg_ramp.sv
// Analog ramp generator with AXI4-Lite register access
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module arg_ramp #(
  parameter int UPDATE_CYCLES = arg_pkg::UPDATE_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [15:0] SCALED_OUTPUT,
  output logic [15:0] CURRENT_LEVEL
);
  import arg_pkg::*;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8],
               strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  function automatic arg_level_t clip(input arg_level_t v,
                                      input arg_level_t lim);
    clip = (v > lim) ? lim : v;
  endfunction : clip

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= REG_OUTPUT);
  endfunction : mapped

  // Bus side state
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [2:0] ctrl;
  logic [15:0] tgt_low;
  logic [15:0] tgt_high;
  logic [15:0] limit;
  logic [15:0] start_stop_offset;
  logic [15:0] rate;
  logic [15:0] gain;
  logic [15:0] offset;
  logic [31:0] rd_data;

  // Ramp state
  arg_state_e state;
  arg_state_e next_state;
  arg_level_t level;
  arg_level_t next_level;
  logic [3:0] frac;
  logic en_q;
  logic stop_q;
  logic tick;

  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire do_write = aw_full && w_full && !S_AXI_BVALID;
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire r_hold = S_AXI_RVALID && !S_AXI_RREADY;

  // Address and data accepted in either order, one write in flight
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
      S_AXI_AWREADY <= !(aw_take || (aw_full && !do_write));
      S_AXI_WREADY <= !(w_take || (w_full && !do_write));
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Configuration writes; status registers ignore writes
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= 3'h0;
      tgt_low <= RST_TGT;
      tgt_high <= RST_TGT;
      limit <= RST_LIMIT;
      start_stop_offset <= RST_START_STOP_OFFSET;
      rate <= RST_RATE;
      gain <= RST_GAIN;
      offset <= RST_OFFSET;
    end else if (do_write) begin
      unique case (aw_addr)
        REG_CTRL: ctrl <= w_strb[0] ? w_data[2:0] : ctrl;
        REG_TGT_LOW: tgt_low <= merge16(tgt_low, w_data, w_strb);
        REG_TGT_HIGH: tgt_high <= merge16(tgt_high, w_data, w_strb);
        REG_LIMIT: limit <= merge16(limit, w_data, w_strb);
        REG_START_STOP_OFFSET: start_stop_offset <= merge16(start_stop_offset, w_data, w_strb);
        REG_RATE: rate <= merge16(rate, w_data, w_strb);
        REG_GAIN: gain <= merge16(gain, w_data, w_strb);
        REG_OFFSET: offset <= merge16(offset, w_data, w_strb);
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Read mux; narrow fields zero-extended
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      REG_CTRL: rd_data = {29'h0, ctrl};
      REG_TGT_LOW: rd_data = {16'h0, tgt_low};
      REG_TGT_HIGH: rd_data = {16'h0, tgt_high};
      REG_LIMIT: rd_data = {16'h0, limit};
      REG_START_STOP_OFFSET: rd_data = {16'h0, start_stop_offset};
      REG_RATE: rd_data = {16'h0, rate};
      REG_GAIN: rd_data = {16'h0, gain};
      REG_OFFSET: rd_data = {16'h0, offset};
      REG_STATUS: rd_data = {28'h0, state == ST_LOCKED, state};
      REG_LEVEL: rd_data = {16'h0, CURRENT_LEVEL};
      REG_OUTPUT: rd_data = {16'h0, SCALED_OUTPUT};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !(ar_take || r_hold);
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_data;
        S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Control edges
  wire en = ctrl[CTRL_EN_BIT];
  wire sel = ctrl[CTRL_SEL_BIT];
  wire stop = ctrl[CTRL_STOP_BIT];
  wire en_rise = en && !en_q;
  wire en_fall = !en && en_q;
  wire stop_rise = stop && !stop_q;

  // start level from offset and start/stop offset
  wire arg_level_t lim_lvl = arg_level_t'($signed(limit));
  wire arg_level_t off_lvl = clip(arg_level_t'($signed(offset)), lim_lvl);
  wire arg_level_t start_raw = arg_level_t'($signed(offset))
                               + arg_level_t'($signed(start_stop_offset));
  wire arg_level_t start_lvl = clip(start_raw, lim_lvl);

  wire arg_level_t sel_lvl = sel ? arg_level_t'($signed(tgt_high))
                                 : arg_level_t'($signed(tgt_low));
  wire arg_level_t ramp_tgt = (state == ST_DECEL) ? start_lvl
                                                  : clip(sel_lvl, lim_lvl);

  // rate held inside its legal span
  wire [13:0] rate_eff = (rate < 16'(RATE_MIN)) ? 14'(RATE_MIN) :
                         (rate > 16'(RATE_MAX)) ? 14'(RATE_MAX) : rate[13:0];
  // tenth of rate per update, remainder carried
  wire [14:0] sum = {11'h0, frac} + {1'b0, rate_eff};
  wire [10:0] move = 11'(sum / 15'(UPDATES_PER_SEC));
  wire [3:0] next_frac = 4'(sum - 15'(move) * 15'(UPDATES_PER_SEC));
  wire arg_level_t step = arg_level_t'({7'h0, move});
  wire arg_level_t up_lvl = level + step;
  wire arg_level_t dn_lvl = level - step;
  // always from the present level, so select changes just retarget
  wire arg_level_t stepped = (level < ramp_tgt) ?
    ((up_lvl > ramp_tgt) ? ramp_tgt : up_lvl) :
    ((dn_lvl < ramp_tgt) ? ramp_tgt : dn_lvl);
  wire ramping = (state == ST_RAMP) || (state == ST_DECEL);

  always_comb begin
    next_state = state;
    next_level = level;
    if (en_fall) begin
      next_level = off_lvl;
      next_state = stop ? ST_LOCKED : ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_level = off_lvl;
          if (en_rise) begin
            next_state = ST_START_HOLD;
            next_level = start_lvl;
          end
        end
        ST_START_HOLD: begin
          if (stop_rise) begin
            next_state = ST_DECEL;
          end else if (tick) begin
            next_state = ST_RAMP;
          end
        end
        ST_RAMP: begin
          // stop turns the ramp toward the start level
          if (stop_rise) begin
            next_state = ST_DECEL;
          end else if (tick) begin
            // level moves only on the update tick
            next_level = clip(stepped, lim_lvl);
          end
        end
        ST_DECEL: begin
          if (level == start_lvl) begin
            next_state = ST_STOP_HOLD;
          end else if (tick) begin
            next_level = clip(stepped, lim_lvl);
          end
        end
        ST_STOP_HOLD: begin
          // hold one full period, then offset
          if (tick) begin
            next_state = ST_LOCKED;
            next_level = off_lvl;
          end
        end
        ST_LOCKED: begin
          next_level = off_lvl;
          // release only once stop and enable are low
          if (!en && !stop) begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Restarting the tick on hold entry makes each hold a full period
  wire tick_clear = (next_state != state) &&
    ((next_state == ST_START_HOLD) || (next_state == ST_STOP_HOLD));

  arg_tick #(.CYCLES(UPDATE_CYCLES)) u_tick (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(tick_clear),
    .tick(tick)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      level <= '0;
      CURRENT_LEVEL <= 16'h0000;
      frac <= 4'h0;
      en_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      state <= next_state;
      level <= next_level;
      CURRENT_LEVEL <= next_level[15:0];
      frac <= !ramping ? 4'h0 : (tick ? next_frac : frac);
      en_q <= en;
      stop_q <= stop;
    end
  end

  // (level - offset) * 100 / gain, gain in hundredths
  arg_div_if #(.W(DIV_W)) div_bus();
  wire arg_level_t diff = level - arg_level_t'($signed(offset));
  wire [DIV_W-1:0] diff_w = DIV_W'($unsigned(diff));
  assign div_bus.start = 1'b1;
  assign div_bus.dividend = diff[17] ? '0 :
                            DIV_W'(diff_w * DIV_W'(GAIN_SCALE));
  // Zero gain at offset would saturate; divide by one so output stays zero
  wire zero_diff = (diff <= arg_level_t'(0));
  assign div_bus.divisor = (gain == 16'h0000 && zero_diff) ? DIV_W'(1)
                           : DIV_W'(gain);

  arg_div #(.W(DIV_W)) u_div (
    .clk(MCLK),
    .rst_n(RST_N),
    .bus(div_bus.server)
  );

  // saturate to the positive 15-bit span
  wire [15:0] out_sat = (div_bus.quotient > DIV_W'(OUT_MAX)) ? OUT_MAX
                        : div_bus.quotient[15:0];

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SCALED_OUTPUT <= 16'h0000;
    end else if (div_bus.done) begin
      SCALED_OUTPUT <= out_sat;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  start_hold_a: assert property (
    state == ST_IDLE && en_rise |=> state == ST_START_HOLD
      && level == $past(start_lvl)) else $error("start level wrong");
  enable_fall_a: assert property (
    en_fall |=> level == $past(off_lvl)) else $error("no drop on disable");
  sel_target_a: assert property (
    state == ST_RAMP && tick && en && !stop_rise && level < ramp_tgt
      && step > arg_level_t'(0)
      |=> level > $past(level)) else $error("ramp not toward target");
  decel_down_a: assert property (
    state == ST_DECEL && level > start_lvl |=> level <= $past(level))
    else $error("decel level rose");
  stop_hold_a: assert property (
    state == ST_STOP_HOLD && tick |=> level == $past(off_lvl))
    else $error("stop hold did not end at offset");
  level_limit_a: assert property (
    ramping && tick |=> level <= $past(lim_lvl)) else $error("over limit");
  step_size_a: assert property (
    state == ST_RAMP && tick && !en_fall && !stop_rise
      |=> (level - $past(level) <= $past(step))
      && ($past(level) - level <= $past(step))) else $error("step too big");
  update_tick_a: assert property (
    state == ST_RAMP && !tick && !en_fall |=> $stable(level))
    else $error("level moved off tick");
  restart_lock_a: assert property (
    state == ST_LOCKED && stop |=> state == ST_LOCKED)
    else $error("left lock while stop high");
  output_range_a: assert property (
    div_bus.done |=> !SCALED_OUTPUT[15]) else $error("output out of range");

  ramp_reached_c: cover property (state == ST_RAMP && level == ramp_tgt);
  decel_done_c: cover property (state == ST_STOP_HOLD ##1 state == ST_LOCKED);
  sel_change_c: cover property (state == ST_RAMP && $changed(sel));
endmodule : arg_ramp
`default_nettype wire

//--- dv/arg_prog_model.sv
// Control program model: AXI4-Lite master that configures the ramp
`timescale 1ns/1ns
`default_nettype none
module arg_prog_model (
  input wire logic clk,
  output var logic [7:0] awaddr,
  output var logic awvalid,
  input wire logic awready,
  output var logic [31:0] wdata,
  output var logic [3:0] wstrb,
  output var logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output var logic bready,
  output var logic [7:0] araddr,
  output var logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output var logic rready
);
  import arg_pkg::*;
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // Each channel held until its own ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        r = bresp;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
  endtask : rd
  function automatic logic [31:0] fit(input int v, input int lo, input int hi);
    return 32'(v < lo ? lo : (v > hi ? hi : v));
  endfunction : fit
  task automatic cfg(input int off, input int start_stop_offset, input int lmt,
                     input int gain, input int tl, input int th);
    logic [1:0] r;
    wr(REG_OFFSET, fit(off, -10000, 10000), r);
    wr(REG_START_STOP_OFFSET, fit(start_stop_offset, 0, 20000), r);
    wr(REG_LIMIT, fit(lmt, -10000, 20000), r);
    wr(REG_GAIN, fit(gain, 0, 1000), r);
    wr(REG_TGT_LOW, fit(tl, -10000, 20000), r);
    wr(REG_TGT_HIGH, fit(th, -10000, 20000), r);
  endtask : cfg
endmodule : arg_prog_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the analog ramp generator
`timescale 1ns/1ns
`default_nettype none
module tb;
  import arg_pkg::*;
  // Short tick keeps the run small; ramp and hold timing derives from it
  localparam int UC = 200;
  typedef struct {int off; int start_stop_offset; int lmt; int gain; int lvl; int out;} arg_row_s;
  arg_row_s rows[6] = '{'{0, 500, 20000, 100, 500, 500},
    '{100, 300, 20000, 50, 400, 600}, '{-200, 0, 20000, 100, -200, 0},
    '{0, 20000, 20000, 10, 20000, 32767}, '{0, 1000, 700, 100, 700, 700},
    '{0, 100, 20000, 0, 100, 32767}};
  logic mclk, rst_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  logic [15:0] scaled_output, current_level;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;
  arg_ramp #(.UPDATE_CYCLES(UC)) dut (.MCLK(mclk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SCALED_OUTPUT(scaled_output), .CURRENT_LEVEL(current_level));
  arg_prog_model prog (.clk(mclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc
  // Follows the level to a target, flagging any step past it
  task automatic ramp_to(input int tgt, input bit up, output int k);
    logic over;
    over = 1'b0;
    k = 0;
    while ($signed(current_level) != tgt && k < 20 * UC) begin
      cyc(1);
      k++;
      if (up ? $signed(current_level) > tgt : $signed(current_level) < tgt)
        over = 1'b1;
    end
    chk("level_reached", current_level, 16'(tgt));
    chk("overshoot", {15'h0000, over}, 16'h0000);
  endtask : ramp_to
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("reset_level", current_level, 16'h0000);
    chk("reset_output", scaled_output, 16'h0000);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    prog.rd(REG_LIMIT, d, r);
    chk("limit_rst", d[15:0], RST_LIMIT);
    prog.rd(REG_RATE, d, r);
    chk("rate_rst", d[15:0], RST_RATE);
    prog.rd(REG_GAIN, d, r);
    chk("gain_rst", d[15:0], RST_GAIN);
    prog.rd(8'h2C, d, r);
    chk("unmapped_rd", {14'h0000, r}, {14'h0000, RESP_SLVERR});
    chk("unmapped_data", d[15:0], 16'h0000);
    prog.wr(8'h30, 32'h00000001, r);
    chk("unmapped_wr", {14'h0000, r}, {14'h0000, RESP_SLVERR});
    prog.wr(REG_LEVEL, 32'h00001234, r);
    chk("ro_wr", {14'h0000, r}, {14'h0000, RESP_OKAY});
    foreach (rows[i]) begin
      prog.cfg(rows[i].off, rows[i].start_stop_offset, rows[i].lmt, rows[i].gain, 0, 0);
      prog.wr(REG_CTRL, 32'h00000001, r);
      cyc(60);
      chk("start_level", current_level, 16'(rows[i].lvl));
      chk("scaled", scaled_output, 16'(rows[i].out));
      prog.rd(REG_OUTPUT, d, r);
      chk("out_reg", d[15:0], 16'(rows[i].out));
      prog.wr(REG_CTRL, 32'h00000000, r);
      // Divider may need two conversions before the drop shows
      cyc(60);
      chk("off_level", current_level, 16'(rows[i].off));
      chk("off_output", scaled_output, 16'h0000);
    end
    prog.cfg(0, 30, 20000, 100, 50, 200);
    prog.wr(REG_CTRL, 32'h00000001, r);
    cyc(UC / 2);
    chk("hold_level", current_level, 16'd30);
    ramp_to(50, 1'b1, n);
    prog.wr(REG_CTRL, 32'h00000003, r);
    ramp_to(200, 1'b1, n);
    chk("sel_time", 16'(n > 14 * UC && n <= 15 * UC + 30), 16'h0001);
    prog.wr(REG_CTRL, 32'h00000007, r);
    ramp_to(30, 1'b0, n);
    chk("decel_time", 16'(n > 16 * UC && n <= 17 * UC + 30), 16'h0001);
    cyc(UC - 20);
    chk("stop_hold", current_level, 16'd30);
    cyc(40);
    chk("stop_off", current_level, 16'h0000);
    prog.rd(REG_STATUS, d, r);
    chk("locked", {12'h000, d[3:0]}, 16'h000D);
    prog.wr(REG_CTRL, 32'h00000004, r);
    prog.wr(REG_CTRL, 32'h00000005, r);
    cyc(UC + 50);
    chk("no_restart", current_level, 16'h0000);
    prog.wr(REG_CTRL, 32'h00000000, r);
    prog.wr(REG_CTRL, 32'h00000001, r);
    cyc(10);
    chk("restart", current_level, 16'd30);
    prog.rd(REG_LEVEL, d, r);
    chk("level_reg", d[15:0], 16'd30);
    prog.wr(REG_CTRL, 32'h00000000, r);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
